/* bench/sbl_top_properties.sv */
// Checker for sbl_top: bus wait timing, active port count, pause and resume pulses.
// Assumes it is bound into sbl_top and sees only its ports.
`timescale 1ns/1ps

module sbl_top_checker #(
	parameter int NUM_PORTS = 3,
	parameter int USAGE_W = 8
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NUM_PORTS*USAGE_W-1:0] port_usage,
	input wire logic [7:0] flow_pause_threshold_low,
	input wire logic [7:0] flow_pause_threshold_high,
	input wire logic [NUM_PORTS-1:0] flow_paused,
	input wire logic [NUM_PORTS-1:0] pause_start,
	input wire logic [NUM_PORTS-1:0] pause_resume,
	input wire logic [15:0] resume_pause_value,
	input wire logic [1:0] active_ports
);
	wire logic [USAGE_W-1:0] use0 = port_usage[USAGE_W-1:0];
	wire logic [USAGE_W-1:0] use1 = port_usage[2*USAGE_W-1:USAGE_W];
	wire logic [USAGE_W-1:0] use2 = port_usage[3*USAGE_W-1:2*USAGE_W];
	wire logic [1:0] act_cnt = 2'(use0 >= 36) + 2'(use1 >= 36) + 2'(use2 >= 36);
	wire logic [7:0] pause_thr = (act_cnt >= 2'h2) ? flow_pause_threshold_low : flow_pause_threshold_high;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence req_taken;
		(avs_read || avs_write) && avs_waitrequest && clk_en;
	endsequence

	wait_answer_a: assert property (req_taken |=> !avs_waitrequest)
		else $error("waitrequest not low after one wait cycle");
	wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
		else $error("new request answered without wait");
	data_stand_a: assert property (!$past(avs_read && avs_waitrequest && clk_en) |-> $stable(avs_readdata))
		else $error("read data changed without a read");
	active_count_a: assert property (active_ports == act_cnt)
		else $error("active port count wrong");
	start_cause_a: assert property (pause_start[0] |-> $past(use0) >= $past(pause_thr) && !$past(flow_paused[0]))
		else $error("pause started below its level");
	start_level_a: assert property ($rose(flow_paused[0]) |-> pause_start[0])
		else $error("pause entered without start pulse");
	resume_fall_a: assert property (pause_resume[0] |-> $fell(flow_paused[0]) && resume_pause_value == 16'h0001)
		else $error("resume pulse without leaving pause or value 1");
	resume_once_a: assert property (pause_resume[0] |=> !pause_resume[0])
		else $error("resume pulse longer than one cycle");
endmodule : sbl_top_checker

bind sbl_top sbl_top_checker #(.NUM_PORTS(NUM_PORTS), .USAGE_W(USAGE_W)) u_sbl_top_checker (.*);

/* bench/sbl_top_tb_top.sv */
// Testbench for sbl_top: register access, drop counters, flood limit and flow control.
// Assumes sbl_pkg and the bound checker are compiled before it.
`timescale 1ns/1ps
`include "sbl_consts.svh"

module sbl_top_tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [23:0] port_usage = 24'h00_0000;
	logic [7:0] flow_pause_threshold_low = 8'h21;
	logic [7:0] flow_pause_threshold_high = 8'h3c;
	logic counter_test = 1'b0;
	logic [7:0] flood_usage = 8'h00;
	logic flood_limit_reached;
	logic drop_valid = 1'b0;
	logic [1:0] drop_port = 2'h0;
	logic [1:0] drop_reason = 2'h0;
	logic [2:0] flow_paused;
	logic [2:0] pause_start;
	logic [2:0] pause_resume;
	logic [15:0] resume_pause_value;
	logic [1:0] active_ports;
	logic [31:0] q;
	int failures = 0;
	int num_checks = 0;

	sbl_top u_sbl_top (.*);

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// Holds the request until waitrequest is seen low at an edge
	// Sampled mid-cycle: what stands there is what the next rising edge sees
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
		logic wait_seen;
		int n;
		n = 0;
		wait_seen = 1'b1;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		while (wait_seen && n < 20) begin
			@(negedge sys_clk);
			wait_seen = (avs_waitrequest !== 1'b0);
			q = avs_readdata;
			@(posedge sys_clk);
			n++;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (wait_seen) begin
			failures++;
			wrap_up();
		end
	endtask : bus

	task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(name, q, exp);
	endtask : rd_chk

	task automatic drop(input logic [1:0] p, input logic [1:0] r);
		@(posedge sys_clk);
		drop_valid <= 1'b1;
		drop_port <= p;
		drop_reason <= r;
		@(posedge sys_clk);
		drop_valid <= 1'b0;
	endtask : drop

	task automatic usage_step(input logic [23:0] u);
		@(posedge sys_clk);
		port_usage <= u;
		@(posedge sys_clk);
		#1;
	endtask : usage_step

	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd_chk("resume reset", `SBL_ADDR_RESUME, 32'h0000_0307);
		rd_chk("flood reset", `SBL_ADDR_FLOOD, 32'h0000_0031);
		rd_chk("drop0 reset", `SBL_ADDR_DROP0, 32'h0000_0000);
		rd_chk("unmapped", 16'h7020, 32'h0000_0000);
		bus(1'b1, `SBL_ADDR_RESUME, 32'hffff_0a12);
		rd_chk("resume write", `SBL_ADDR_RESUME, 32'h0000_0a12);
		avs_byteenable <= 4'h2;
		bus(1'b1, `SBL_ADDR_RESUME, 32'h0000_05ee);
		avs_byteenable <= 4'hf;
		rd_chk("resume lane1", `SBL_ADDR_RESUME, 32'h0000_0512);
		bus(1'b1, `SBL_ADDR_FLOOD, 32'hffff_ff40);
		rd_chk("flood write", `SBL_ADDR_FLOOD, 32'h0000_0040);
		bus(1'b1, `SBL_ADDR_DROP1, 32'h0000_0055);
		@(posedge sys_clk);
		flood_usage <= 8'h3f;
		#1;
		check("flood below", {31'h0, flood_limit_reached}, 32'h0000_0000);
		@(posedge sys_clk);
		flood_usage <= 8'h40;
		#1;
		check("flood at limit", {31'h0, flood_limit_reached}, 32'h0000_0001);
		for (int r = 0; r < 4; r++) drop(2'h1, 2'(r));
		drop(2'h3, 2'h1);
		drop(2'h0, 2'h2);
		rd_chk("drop1 count", `SBL_ADDR_DROP1, 32'h0000_0003);
		rd_chk("drop1 cleared", `SBL_ADDR_DROP1, 32'h0000_0000);
		rd_chk("drop0 count", `SBL_ADDR_DROP0, 32'h0000_0001);
		rd_chk("drop2 count", `SBL_ADDR_DROP2, 32'h0000_0000);
		@(posedge sys_clk);
		counter_test <= 1'b1;
		rd_chk("test read", `SBL_ADDR_DROP2, 32'h0000_0000);
		rd_chk("test load", `SBL_ADDR_DROP2, 32'h07ff_fffc);
		// Frozen clock enable must swallow the first drop
		clk_en <= 1'b0;
		drop(2'h2, 2'h1);
		clk_en <= 1'b1;
		drop(2'h2, 2'h3);
		rd_chk("drop2 frozen", `SBL_ADDR_DROP2, 32'h07ff_fffd);
		// One active port, then none: high resume field 12h in use
		usage_step(24'h00_0040);
		check("pause start", {29'h0, pause_start}, 32'h0000_0001);
		check("one active", {30'h0, active_ports}, 32'h0000_0001);
		usage_step(24'h00_0013);
		check("held above", {29'h0, flow_paused}, 32'h0000_0001);
		usage_step(24'h00_0012);
		check("resume one", {29'h0, pause_resume}, 32'h0000_0001);
		check("pause value", {16'h0, resume_pause_value}, 32'h0000_0001);
		// Three active ports, then two: low resume field 05h in use
		usage_step(24'h24_2430);
		check("three active", {30'h0, active_ports}, 32'h0000_0003);
		check("pause again", {31'h0, flow_paused[0]}, 32'h0000_0001);
		usage_step(24'h24_2406);
		check("held low field", {31'h0, flow_paused[0]}, 32'h0000_0001);
		usage_step(24'h24_2405);
		check("resume low", {31'h0, pause_resume[0]}, 32'h0000_0001);
		// Mid-run reset must restore the register defaults
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd_chk("resume rearm", `SBL_ADDR_RESUME, 32'h0000_0307);
		check("value cleared", {16'h0, resume_pause_value}, 32'h0000_0000);
		wrap_up();
	end
endmodule : sbl_top_tb_top

/* core/sbl_drop_counter.sv */
// One saturating, clear-on-read dropped-packet counter.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/1ps
`include "sbl_consts.svh"

module sbl_drop_counter
	import sbl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic inc,
	input wire logic clr,
	input wire logic test_load,
	output logic [31:0] count
);
	logic [31:0] count_ff;
	logic [31:0] nxt_count;
	wire [31:0] clr_base = test_load ? `SBL_COUNT_TEST : `SBL_COUNT_RST;
	wire at_max = (count_ff == `SBL_COUNT_MAX);

	// A drop in the clearing cycle is kept, so no event is lost
	always_comb begin
		if (clr) begin
			nxt_count = clr_base + {31'h0000_0000, inc};
		end else if (inc && !at_max) begin
			nxt_count = count_ff + 32'h0000_0001;
		end else begin
			nxt_count = count_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_ff <= `SBL_COUNT_RST;
		end else if (clk_en) begin
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;
endmodule : sbl_drop_counter

/* core/sbl_top.sv */
// Buffer level thresholds, flow control hysteresis and drop counters.
// Assumes the switch core supplies usage, pause levels and drop events
// synchronous to sys_clk; host reaches registers over Avalon-MM.
//
// Function
// - When a port's usage falls to the selected resume threshold, a pause frame with value 1 is requested.
// - With 2 or 3 active ports the resume threshold is bits 15:8, reset 03h.
// - With 0 or 1 active ports the resume threshold is bits 7:0, reset 07h.
// - A port with 36 buffers in use counts as active when choosing thresholds.
// - Every threshold counts buffers of 128 bytes each.
// - Flood traffic may hold at most the 8-bit limit in bits 7:0, reset 31h.
// - Ports 0, 1 and 2 each have their own 32-bit drop counter, bumped only by their own drops.
// - Drops for buffer space, red rate and random yellow discards are all counted.
// - Reading a drop counter returns its value and clears it; reset value is zero.
// - A drop counter stops at FFFF_FFFFh and never wraps.
// - Pause starts at the pause threshold and ends at the resume threshold, per port.
// - With counter test set, a read loads the counter with 7FFF_FFC instead of zero.
`timescale 1ns/1ps
`include "sbl_consts.svh"

module sbl_top
	import sbl_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter int USAGE_W = 8
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Avalon-MM slave, byte addressed
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Per-port usage from the switch core, packed port 0 lowest
	input wire logic [NUM_PORTS*USAGE_W-1:0] port_usage,
	// Pause thresholds from the neighbouring pause level register
	input wire logic [7:0] flow_pause_threshold_low,
	input wire logic [7:0] flow_pause_threshold_high,
	// Counter test bit from the buffer manager config register
	input wire logic counter_test,
	// Flood traffic usage
	input wire logic [7:0] flood_usage,
	output logic flood_limit_reached,
	// Drop events
	input wire logic drop_valid,
	input wire logic [1:0] drop_port,
	input wire logic [1:0] drop_reason,
	// Flow control towards the MACs
	output logic [NUM_PORTS-1:0] flow_paused,
	output logic [NUM_PORTS-1:0] pause_start,
	output logic [NUM_PORTS-1:0] pause_resume,
	output logic [15:0] resume_pause_value,
	output logic [1:0] active_ports
);
	generate
		if (NUM_PORTS != 3) begin : g_bad_ports
			$error("sbl_top supports exactly three ports");
		end
		if (USAGE_W < 6 || USAGE_W > 8) begin : g_bad_usage
			$error("sbl_top usage width must be 6 to 8 bits");
		end
	endgenerate

	// Register state
	logic [7:0] resume_low_ff;
	logic [7:0] resume_high_ff;
	logic [7:0] flood_limit_ff;
	logic [31:0] readdata_ff;
	sbl_bus_state_t bus_state_ff;
	sbl_bus_state_t nxt_bus_state;
	logic [NUM_PORTS-1:0] paused_ff;
	logic [NUM_PORTS-1:0] nxt_paused;
	logic [NUM_PORTS-1:0] start_ff;
	logic [NUM_PORTS-1:0] resume_ff;
	logic [15:0] pause_value_ff;

	// Bus decode
	wire bus_req = avs_read | avs_write;
	wire bus_take = bus_req && (bus_state_ff == SBL_BUS_IDLE);
	wire rd_take = bus_take && avs_read;
	wire wr_take = bus_take && avs_write;
	wire sel_resume = (avs_address == `SBL_ADDR_RESUME);
	wire sel_flood = (avs_address == `SBL_ADDR_FLOOD);
	wire sel_drop0 = (avs_address == `SBL_ADDR_DROP0);
	wire sel_drop1 = (avs_address == `SBL_ADDR_DROP1);
	wire sel_drop2 = (avs_address == `SBL_ADDR_DROP2);
	wire [NUM_PORTS-1:0] sel_drop = {sel_drop2, sel_drop1, sel_drop0};
	wire wr_resume = wr_take && sel_resume;
	wire wr_flood = wr_take && sel_flood;

	// One wait cycle: the request is taken, then answered on the next edge
	assign avs_waitrequest = bus_req && (bus_state_ff == SBL_BUS_IDLE);
	assign avs_readdata = readdata_ff;

	always_comb begin
		case (bus_state_ff)
			SBL_BUS_IDLE: begin
				nxt_bus_state = bus_req ? SBL_BUS_ANSWER : SBL_BUS_IDLE;
			end
			SBL_BUS_ANSWER: begin
				nxt_bus_state = SBL_BUS_IDLE;
			end
			default: begin
				nxt_bus_state = SBL_BUS_IDLE;
			end
		endcase
	end

	// Drop counters
	wire drop_counted = drop_valid && (drop_reason != SBL_DROP_NONE);
	logic [31:0] drop_count [NUM_PORTS];

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_drop
			wire port_hit = drop_counted && (drop_port == 2'(gp));
			sbl_drop_counter u_cnt (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.clk_en(clk_en),
				.inc(port_hit),
				.clr(rd_take && sel_drop[gp]),
				.test_load(counter_test),
				.count(drop_count[gp])
			);
		end
	endgenerate

	// Read mux; value is captured in the same edge that clears the counter
	wire [31:0] rd_resume = {16'h0000, resume_low_ff, resume_high_ff};
	wire [31:0] rd_flood = {24'h00_0000, flood_limit_ff};
	wire [31:0] rd_value = sel_resume ? rd_resume :
		sel_flood ? rd_flood :
		sel_drop0 ? drop_count[0] :
		sel_drop1 ? drop_count[1] :
		sel_drop2 ? drop_count[2] : 32'h0000_0000;

	// Register writes honour byte lanes; upper bits are not stored
	wire [7:0] nxt_resume_high = avs_byteenable[0] ? avs_writedata[7:0] : resume_high_ff;
	wire [7:0] nxt_resume_low = avs_byteenable[1] ? avs_writedata[15:8] : resume_low_ff;
	wire [7:0] nxt_flood = avs_byteenable[0] ? avs_writedata[7:0] : flood_limit_ff;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_state_ff <= SBL_BUS_IDLE;
			readdata_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			bus_state_ff <= nxt_bus_state;
			if (rd_take) begin
				readdata_ff <= rd_value;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			resume_low_ff <= `SBL_RESUME_LOW_RST;
			resume_high_ff <= `SBL_RESUME_HIGH_RST;
			flood_limit_ff <= `SBL_FLOOD_RST;
		end else if (clk_en) begin
			if (wr_resume) begin
				resume_low_ff <= nxt_resume_low;
				resume_high_ff <= nxt_resume_high;
			end
			if (wr_flood) begin
				flood_limit_ff <= nxt_flood;
			end
		end
	end

	// Active port count and threshold choice, all in 128-byte buffers
	logic [NUM_PORTS-1:0] port_active;
	logic [USAGE_W-1:0] usage [NUM_PORTS];

	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_usage
			assign usage[gp] = port_usage[gp*USAGE_W +: USAGE_W];
			assign port_active[gp] = (8'(usage[gp]) >= `SBL_ACTIVE_BUFFERS);
		end
	endgenerate

	wire [1:0] n_active = {1'b0, port_active[0]} + {1'b0, port_active[1]} + {1'b0, port_active[2]};
	wire multi_active = (n_active >= `SBL_MULTI_ACTIVE);
	wire [7:0] resume_thr = multi_active ? resume_low_ff : resume_high_ff;
	wire [7:0] pause_thr = multi_active ? flow_pause_threshold_low : flow_pause_threshold_high;

	// Flood cap: at the limit further flood traffic must be refused
	assign flood_limit_reached = (flood_usage >= flood_limit_ff);

	// Hysteresis: a paused port stays paused until usage falls to resume level
	logic [NUM_PORTS-1:0] go_pause;
	logic [NUM_PORTS-1:0] go_resume;

	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_flow
			wire [7:0] u8 = 8'(usage[gp]);
			assign go_pause[gp] = !paused_ff[gp] && (u8 >= pause_thr);
			assign go_resume[gp] = paused_ff[gp] && (u8 <= resume_thr);
			assign nxt_paused[gp] = go_pause[gp] ? 1'b1 : (go_resume[gp] ? 1'b0 : paused_ff[gp]);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			paused_ff <= '0;
			start_ff <= '0;
			resume_ff <= '0;
			pause_value_ff <= 16'h0000;
		end else if (clk_en) begin
			paused_ff <= nxt_paused;
			start_ff <= go_pause;
			resume_ff <= go_resume;
			if (|go_resume) begin
				pause_value_ff <= `SBL_RESUME_PAUSE_VALUE;
			end
		end
	end

	assign flow_paused = paused_ff;
	assign pause_start = start_ff;
	assign pause_resume = resume_ff;
	assign resume_pause_value = pause_value_ff;
	assign active_ports = n_active;
endmodule : sbl_top

/* inc/sbl_consts.svh */
// Constants for the switch buffer levels and drop counters block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH

// Register indices; byte address is four times the index
`define SBL_IDX_RESUME 16'h1c03
`define SBL_IDX_FLOOD 16'h1c04
`define SBL_IDX_DROP0 16'h1c05
`define SBL_IDX_DROP1 16'h1c06
`define SBL_IDX_DROP2 16'h1c07
`define SBL_ADDR_RESUME 16'h700c
`define SBL_ADDR_FLOOD 16'h7010
`define SBL_ADDR_DROP0 16'h7014
`define SBL_ADDR_DROP1 16'h7018
`define SBL_ADDR_DROP2 16'h701c

// Field layout of the resume threshold register
`define SBL_RESUME_LOW_MSB 15
`define SBL_RESUME_LOW_LSB 8
`define SBL_RESUME_HIGH_MSB 7
`define SBL_RESUME_HIGH_LSB 0
`define SBL_RESUME_W 16
`define SBL_FLOOD_W 8

// Reset values
`define SBL_RESUME_LOW_RST 8'h03
`define SBL_RESUME_HIGH_RST 8'h07
`define SBL_FLOOD_RST 8'h31
`define SBL_COUNT_RST 32'h0000_0000
`define SBL_COUNT_MAX 32'hffff_ffff
`define SBL_COUNT_TEST 32'h07ff_fffc

// Flow control figures
`define SBL_ACTIVE_BUFFERS 8'h24
`define SBL_MULTI_ACTIVE 2'h2
`define SBL_BUFFER_BYTES 128
`define SBL_RESUME_PAUSE_VALUE 16'h0001

`endif

/* inc/sbl_pkg.sv */
// Types for the switch buffer levels and drop counters block.
// Assumes sbl_consts.svh on the include path.
`include "sbl_consts.svh"

package sbl_pkg;
	typedef enum logic [1:0] {
		SBL_DROP_NONE,
		SBL_DROP_SPACE,
		SBL_DROP_RED,
		SBL_DROP_YELLOW
	} sbl_drop_reason_t;

	typedef enum {
		SBL_BUS_IDLE,
		SBL_BUS_ANSWER
	} sbl_bus_state_t;
endpackage : sbl_pkg
